// [logic/wake_cfg_pkg.sv]
// Purpose: shared constants for the wake input configuration block
// Assumes: 20 MHz clock, registers one word each on a plain port
// Notes:   offsets are byte addresses of aligned words
package wake_cfg_pkg;

  // ==========================================================
  // clock and filter timing
  localparam int unsigned CLK_FREQ_KHZ  = 20000;
  localparam int unsigned FLT_SHORT_US  = 16;
  localparam int unsigned FLT_LONG_US   = 64;
  localparam int unsigned FLT_SHORT_CYC = (FLT_SHORT_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int unsigned FLT_LONG_CYC  = (FLT_LONG_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int unsigned FLT_CNT_W     = 11;

  // ==========================================================
  // geometry
  localparam int unsigned NUM_INPUTS = 3;
  localparam int unsigned ADDR_W     = 8;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_PULL_SELECT   = 8'h00;
  localparam logic [7:0] OFS_DETECT_FILTER = 8'h04;
  localparam logic [7:0] OFS_WAKE_ENABLE   = 8'h08;
  localparam logic [7:0] OFS_MEASURE_CTRL  = 8'h0c;
  localparam logic [7:0] OFS_WAKE_STATUS   = 8'h10;
  localparam logic [7:0] OFS_LEVEL_STATUS  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK      = 8'h18;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned STAT_SPI_FAIL_BIT = 3;
  localparam int unsigned STAT_W            = 4;
  localparam logic [5:0]  PULL_SELECT_RST   = 6'h00;
  localparam logic [5:0]  DETECT_FILTER_RST = 6'h00;
  localparam logic [2:0]  WAKE_ENABLE_RST   = 3'h0;
  localparam logic        MEASURE_RST       = 1'b0;
  localparam logic [3:0]  IRQ_MASK_RST      = 4'h0;

  // ==========================================================
  // pull and detection codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;
  localparam logic [1:0] DET_STATIC_SHORT = 2'h0;
  localparam logic [1:0] DET_STATIC_LONG  = 2'h1;
  localparam logic [1:0] DET_CYCLIC_T1    = 2'h2;
  localparam logic [1:0] DET_CYCLIC_T2    = 2'h3;

  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_SLEEP,
    MODE_RESTART,
    MODE_FAIL_SAFE
  } dev_mode_e;

endpackage : wake_cfg_pkg

// [logic/wake_filter.sv]
// Purpose: glitch filter for one wake input
// Assumes: level_i is already synchronised to clk_i
// Notes:   the counter restarts on every threshold crossing
module wake_filter
  import wake_cfg_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic level_i,
  input  wire logic active_i,
  input  wire logic long_i,
  output logic      level_o,
  output logic      event_o
);

  // ==========================================================
  // filter counter
  logic                 prev_raw;
  logic [FLT_CNT_W-1:0] count;
  wire                  crossing = level_i != prev_raw;
  wire  [FLT_CNT_W-1:0] limit    = long_i ? FLT_CNT_W'(FLT_LONG_CYC - 1)
                                          : FLT_CNT_W'(FLT_SHORT_CYC - 1);
  wire                  pending  = active_i && !crossing && (level_i != level_o);
  wire                  done     = pending && (count == limit);

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prev_raw <= 1'b0;
      count    <= '0;
      level_o  <= 1'b0;
      event_o  <= 1'b0;
    end
    else
    begin
      prev_raw <= level_i;
      event_o  <= done; // R12
      if (!pending || done)
        count <= '0; // R14
      else
        count <= count + FLT_CNT_W'(1); // R14
      if (done)
        level_o <= level_i; // R12
    end
  end

  // ==========================================================
  // checks
  property p_filter_restart;
    @(posedge clk_i) disable iff (!reset_n_i)
      crossing |=> count == '0;
  endproperty
  a_filter_restart: assert property (p_filter_restart) // R14
    else $error("filter counter did not restart on a crossing");

  property p_filter_stable;
    @(posedge clk_i) disable iff (!reset_n_i)
      $rose(event_o) && !long_i && $past(active_i) |->
        $past(level_i) == level_o && $past(!crossing);
  endproperty
  a_filter_stable: assert property (p_filter_stable) // R12
    else $error("wake accepted while input was still moving");

endmodule // wake_filter

// [logic/wake_input_config_measure.sv]
// Purpose: wake input pulls, detection filters and measurement switch
// Assumes: pins are asynchronous; mode, timers and sleep command share clk_i
// Notes:   registers reached over a plain port, read data one cycle later
//
// Decided for this implementation: the strobed register port and the address map.

// Functional notes
// [R1] each input has a two-bit pull code: none (reset), pull-down, pull-up or automatic.
// [R2] automatic pull drives the pull-up while the input reads high, the pull-down while low.
// [R3] detection codes 00 and 01 are static sensing with a 16 us or 64 us filter.
// [R4] codes 10 and 11 are cyclic sensing on the first or second timer, with a 16 us filter.
// [R5] software must also give the same timer to the high-side output feeding that input.
// [R6] after reset measurement is off, the switch open and inputs one and two wake normally.
// [R7] with measurement enabled the switch closes only in Normal mode, open otherwise.
// [R8] with measurement enabled inputs one and two lose their pulls and their wake and level signals.
// [R9] with measurement enabled their settings still store but have no effect.
// [R10] with measurement enabled the wake and level status ignore inputs one and two.
// [R11] sleep command with measurement on and only inputs one or two as wake sources sets the failure flag and restarts.
// [R12] a crossing starts the filter, and a wake counts only if the level holds for the whole filter time.
// [R13] both edges of an enabled input are wake events: interrupt in Normal and Stop, wake-up in Sleep and Fail-Safe.
// [R14] filter time is counted in clock cycles, restarting at each crossing.
module wake_input_config_measure
  import wake_cfg_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  write_i,
  input  wire logic                  read_i,
  output logic      [31:0]           rdata_o,
  input  wire logic [NUM_INPUTS-1:0] wake_pin_i,
  input  wire logic [2:0]            mode_i,
  input  wire logic                  first_timer_on_i,
  input  wire logic                  second_timer_on_i,
  input  wire logic                  sleep_cmd_i,
  output logic      [NUM_INPUTS-1:0] pull_up_en_o,
  output logic      [NUM_INPUTS-1:0] pull_down_en_o,
  output logic                       measure_switch_o,
  output logic                       wakeup_o,
  output logic                       go_sleep_o,
  output logic                       restart_req_o,
  output logic                       irq_o
);

  // ==========================================================
  // decoding helpers
  function automatic logic [1:0] pull_drive(input logic [1:0] code, input logic lvl);
    // returns {up, down}
    unique case (code)
      PULL_NONE: pull_drive = 2'b00;
      PULL_DOWN: pull_drive = 2'b01;
      PULL_UP:   pull_drive = 2'b10;
      PULL_AUTO: pull_drive = lvl ? 2'b10 : 2'b01;
    endcase
  endfunction

  function automatic logic field_active(input logic [1:0] code, input logic t1, input logic t2);
    unique case (code)
      DET_STATIC_SHORT,
      DET_STATIC_LONG: field_active = 1'b1;
      DET_CYCLIC_T1:   field_active = t1;
      DET_CYCLIC_T2:   field_active = t2;
    endcase
  endfunction

  // ==========================================================
  // registers
  logic [5:0]            pull_select_register;
  logic [5:0]            detect_filter_register;
  logic [2:0]            wake_enable_register;
  logic                  measure_enable;
  logic [STAT_W-1:0]     wake_status_primary;
  logic [NUM_INPUTS-1:0] input_level_status;
  logic [STAT_W-1:0]     irq_mask;

  wire dev_mode_e mode      = dev_mode_e'(mode_i);
  wire            wr_pull   = write_i && addr_i == OFS_PULL_SELECT;
  wire            wr_detect = write_i && addr_i == OFS_DETECT_FILTER;
  wire            wr_enable = write_i && addr_i == OFS_WAKE_ENABLE;
  wire            wr_meas   = write_i && addr_i == OFS_MEASURE_CTRL;
  wire            wr_status = write_i && addr_i == OFS_WAKE_STATUS;
  wire            wr_mask   = write_i && addr_i == OFS_IRQ_MASK;

  // ==========================================================
  // pin synchronisers
  logic [NUM_INPUTS-1:0] pin_meta;
  logic [NUM_INPUTS-1:0] pin_sync;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= wake_pin_i;
      pin_sync <= pin_meta;
    end
  end

  // ==========================================================
  // per-input filters; inputs one and two are gated while measuring
  wire  [NUM_INPUTS-1:0] gated = {1'b0, {2{measure_enable}}}; // R8 R9
  logic [NUM_INPUTS-1:0] filt_level;
  logic [NUM_INPUTS-1:0] filt_event;
  logic [NUM_INPUTS-1:0] next_pull_up;
  logic [NUM_INPUTS-1:0] next_pull_down;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_input
      wire [1:0] det  = detect_filter_register[2*gi +: 2];
      wire [1:0] pull = pull_select_register[2*gi +: 2];
      wire [1:0] drv  = pull_drive(pull, filt_level[gi]); // R1 R2

      wake_filter u_filter (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .level_i   (pin_sync[gi]),
        .active_i  (field_active(det, first_timer_on_i, second_timer_on_i) && !gated[gi]), // R4
        .long_i    (det == DET_STATIC_LONG), // R3
        .level_o   (filt_level[gi]),
        .event_o   (filt_event[gi])
      );

      assign next_pull_up[gi]   = drv[1] && !gated[gi]; // R8
      assign next_pull_down[gi] = drv[0] && !gated[gi]; // R8
    end
  endgenerate

  // ==========================================================
  // wake events and sleep check
  wire [NUM_INPUTS-1:0] wake_ok    = filt_event & wake_enable_register & ~gated; // R10 R13
  wire                  low_power  = mode == MODE_SLEEP || mode == MODE_FAIL_SAFE;
  // while measuring, only input one or two enabled means nothing could ever wake the device
  wire                  sleep_bad  = sleep_cmd_i && measure_enable && !wake_enable_register[2]
                                     && |wake_enable_register[1:0]; // R11
  wire [STAT_W-1:0]     status_set = {sleep_bad, wake_ok};
  wire [STAT_W-1:0]     status_clr = wr_status ? wdata_i[STAT_W-1:0] : '0;

  // ==========================================================
  // register writes; set wins over clear on the status bits
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pull_select_register   <= PULL_SELECT_RST; // R1
      detect_filter_register <= DETECT_FILTER_RST;
      wake_enable_register   <= WAKE_ENABLE_RST;
      measure_enable         <= MEASURE_RST; // R6
      irq_mask               <= IRQ_MASK_RST;
      wake_status_primary    <= '0;
    end
    else
    begin
      if (wr_pull)
        pull_select_register <= wdata_i[5:0]; // R9
      if (wr_detect)
        detect_filter_register <= wdata_i[5:0]; // R9
      if (wr_enable)
        wake_enable_register <= wdata_i[2:0]; // R9
      if (wr_meas)
        measure_enable <= wdata_i[0];
      if (wr_mask)
        irq_mask <= wdata_i[STAT_W-1:0];
      wake_status_primary <= (wake_status_primary & ~status_clr) | status_set; // R10 R11
    end
  end

  // ==========================================================
  // level status, pins and mode requests
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      input_level_status <= '0;
      pull_up_en_o       <= '0;
      pull_down_en_o     <= '0;
      measure_switch_o   <= 1'b0; // R6
      wakeup_o           <= 1'b0;
      go_sleep_o         <= 1'b0;
      restart_req_o      <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_INPUTS; i++)
        if (!gated[i])
          input_level_status[i] <= filt_level[i]; // R10
      pull_up_en_o     <= next_pull_up;
      pull_down_en_o   <= next_pull_down;
      measure_switch_o <= measure_enable && mode == MODE_NORMAL; // R7
      wakeup_o         <= |wake_ok && low_power; // R13
      go_sleep_o       <= sleep_cmd_i && !sleep_bad;
      restart_req_o    <= sleep_bad; // R11
    end
  end

  // interrupt only carries meaning in Normal and Stop; the mode logic ignores it otherwise
  assign irq_o = |(wake_status_primary & irq_mask); // R13

  // ==========================================================
  // register reads
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = '0;
    unique case (addr_i)
      OFS_PULL_SELECT:   rd_mux[5:0] = pull_select_register;
      OFS_DETECT_FILTER: rd_mux[5:0] = detect_filter_register;
      OFS_WAKE_ENABLE:   rd_mux[2:0] = wake_enable_register;
      OFS_MEASURE_CTRL:  rd_mux[0]   = measure_enable;
      OFS_WAKE_STATUS:   rd_mux[STAT_W-1:0] = wake_status_primary;
      OFS_LEVEL_STATUS:  rd_mux[NUM_INPUTS-1:0] = input_level_status;
      OFS_IRQ_MASK:      rd_mux[STAT_W-1:0] = irq_mask;
      default:           rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_o <= '0;
    else
      rdata_o <= read_i ? rd_mux : '0;
  end

  // ==========================================================
  // checks
  property p_pull_off;
    @(posedge clk_i) disable iff (!reset_n_i)
      pull_select_register[5:4] == PULL_NONE |=> !pull_up_en_o[2] && !pull_down_en_o[2];
  endproperty
  a_pull_off: assert property (p_pull_off) // R1
    else $error("pull active with code none");

  property p_auto_pull;
    @(posedge clk_i) disable iff (!reset_n_i)
      pull_select_register[5:4] == PULL_AUTO |=>
        pull_up_en_o[2] == $past(filt_level[2]) && pull_down_en_o[2] == !$past(filt_level[2]);
  endproperty
  a_auto_pull: assert property (p_auto_pull) // R2
    else $error("automatic pull does not follow the level");

  property p_switch_normal;
    @(posedge clk_i) disable iff (!reset_n_i)
      measure_enable && mode == MODE_NORMAL |=> measure_switch_o;
  endproperty
  a_switch_normal: assert property (p_switch_normal) // R7
    else $error("switch open while measuring in Normal");

  property p_switch_open;
    @(posedge clk_i) disable iff (!reset_n_i)
      !measure_enable || mode != MODE_NORMAL |=> !measure_switch_o;
  endproperty
  a_switch_open: assert property (p_switch_open) // R6 R7
    else $error("switch closed outside measurement in Normal");

  property p_meas_pulls;
    @(posedge clk_i) disable iff (!reset_n_i)
      measure_enable && $past(measure_enable) |->
        pull_up_en_o[1:0] == 2'b00 && pull_down_en_o[1:0] == 2'b00;
  endproperty
  a_meas_pulls: assert property (p_meas_pulls) // R8
    else $error("pull current on a gated input");

  property p_meas_status;
    @(posedge clk_i) disable iff (!reset_n_i)
      measure_enable |=> (wake_status_primary[1:0] & ~$past(wake_status_primary[1:0])) == 2'b00
        && $stable(input_level_status[1:0]);
  endproperty
  a_meas_status: assert property (p_meas_status) // R10
    else $error("status updated by a gated input");

  property p_sleep_fail;
    @(posedge clk_i) disable iff (!reset_n_i)
      sleep_bad |=> restart_req_o && wake_status_primary[STAT_SPI_FAIL_BIT] && !go_sleep_o;
  endproperty
  a_sleep_fail: assert property (p_sleep_fail) // R11
    else $error("bad sleep command not refused");

  property p_wake_event;
    @(posedge clk_i) disable iff (!reset_n_i)
      filt_event[2] && wake_enable_register[2] |=>
        wake_status_primary[2] && (wakeup_o == $past(low_power));
  endproperty
  a_wake_event: assert property (p_wake_event) // R13
    else $error("enabled wake event not reported");

  // a cyclic input must ignore its pin while its timer is off
  property p_cyclic_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
      (detect_filter_register[5:4] == DET_CYCLIC_T1 && !first_timer_on_i)
        || (detect_filter_register[5:4] == DET_CYCLIC_T2 && !second_timer_on_i)
        |=> !filt_event[2];
  endproperty
  a_cyclic_hold: assert property (p_cyclic_hold) // R4
    else $error("cyclic input filtered while its timer was off");

  property p_sleep_ok;
    @(posedge clk_i) disable iff (!reset_n_i)
      sleep_cmd_i && !sleep_bad |=> go_sleep_o && !restart_req_o;
  endproperty
  a_sleep_ok: assert property (p_sleep_ok) // R11
    else $error("valid sleep command refused");

endmodule // wake_input_config_measure

// [testbench/wake_partner.sv]
// Purpose: external circuits that sit on the three wake pins
// Assumes: the third circuit is powered by a high-side output that follows its timer; the other two are always powered
// Notes:   an unpowered circuit lets go of its pin, so only the pulls hold it
module wake_partner
(
  input  wire logic       clk_i,
  input  wire logic [2:0] drive_val_i,
  input  wire logic [2:0] supply_i,
  input  wire logic [2:0] pull_up_i,
  input  wire logic [2:0] pull_down_i,
  output logic      [2:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // pin resolution
  logic [2:0] flutter = 3'h5;

  // a floating pin never holds long enough to pass a filter
  always @(posedge clk_i) flutter <= ~flutter;

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (supply_i[i]) pin_o[i] = drive_val_i[i];
      else if (pull_up_i[i]) pin_o[i] = 1'b1;
      else if (pull_down_i[i]) pin_o[i] = 1'b0;
      else pin_o[i] = flutter[i];
    end
  end
endmodule // wake_partner

// [testbench/tb.sv]
// Purpose: self-checking bench for the wake input configuration block
// Assumes: 20 MHz clock, pins driven through the partner circuits
// Notes:   expected values come from the register model kept below
module tb
  import wake_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // stimulus and observed signals
  logic              clk = 1'b0, reset_n = 1'b0, write = 1'b0, read = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic [2:0]        mode = 3'h1, drive = 3'h0, pins, pu, pd;
  logic              t1 = 1'b1, t2 = 1'b1, sleep_cmd = 1'b0, hs_sel = 1'b0;
  logic              sw, wakeup, go_sleep, restart, irq;
  logic [15:0]       seed = 16'h3e10;
  int fails = 0, checks_done = 0, cycles = 0, wake_cnt = 0;
  int m_pull = 0, m_det = 0, m_en = 0, m_meas = 0, m_mask = 0, m_stat = 0, m_lvl = 0;

  wake_input_config_measure u_wake_input_config_measure (
    .clk_i(clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata), .write_i(write),
    .read_i(read), .rdata_o(rdata), .wake_pin_i(pins), .mode_i(mode),
    .first_timer_on_i(t1), .second_timer_on_i(t2), .sleep_cmd_i(sleep_cmd),
    .pull_up_en_o(pu), .pull_down_en_o(pd), .measure_switch_o(sw), .wakeup_o(wakeup),
    .go_sleep_o(go_sleep), .restart_req_o(restart), .irq_o(irq));

  wake_partner u_wake_partner (.clk_i(clk), .drive_val_i(drive),
    .supply_i({hs_sel ? t2 : t1, 2'b11}), .pull_up_i(pu), .pull_down_i(pd), .pin_o(pins));

  initial forever #25 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (wakeup === 1'b1) wake_cnt++;
    if (cycles == 40000)
    begin
      fails++;
      end_sim();
    end
  end

  // ==========================================================
  // helpers
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  function int exp_reg(input logic [7:0] a);
    case (a)
      OFS_PULL_SELECT:   return m_pull;
      OFS_DETECT_FILTER: return m_det;
      OFS_WAKE_ENABLE:   return m_en;
      OFS_MEASURE_CTRL:  return m_meas;
      OFS_WAKE_STATUS:   return m_stat;
      OFS_LEVEL_STATUS:  return m_lvl;
      OFS_IRQ_MASK:      return m_mask;
      default:           return 0;
    endcase
  endfunction

  task wr(input logic [7:0] a, input int d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clk);
    write <= 1'b0;
    case (a)
      OFS_PULL_SELECT:   m_pull = d & 63;
      OFS_DETECT_FILTER: m_det = d & 63;
      OFS_WAKE_ENABLE:   m_en = d & 7;
      OFS_MEASURE_CTRL:  m_meas = d & 1;
      OFS_WAKE_STATUS:   m_stat = m_stat & ~d;
      OFS_IRQ_MASK:      m_mask = d & 15;
      default:           ;
    endcase
  endtask

  task rd(input logic [7:0] a, input string msg);
    @(posedge clk);
    addr <= a;
    read <= 1'b1;
    @(posedge clk);
    read <= 1'b0;
    #1 chk(rdata, exp_reg(a), msg);
  endtask

  task chk_pulls;
    int up, dn, code, lv;
    up = 0;
    dn = 0;
    for (int i = 0; i < 3; i++)
    begin
      code = (m_pull >> (2 * i)) & 3;
      lv = (m_lvl >> i) & 1;
      if (!(m_meas == 1 && i < 2))
      begin
        up |= int'(code == 2 || (code == 3 && lv == 1)) << i;
        dn |= int'(code == 1 || (code == 3 && lv == 0)) << i;
      end
    end
    chk({pu, pd}, {up[2:0], dn[2:0]}, "pull enables");
  endtask

  // caller has already changed the pin; lo and hi bracket the filter end
  task edge_chk(input int b, input int v, input int lo, input int hi, input int wk);
    int w0;
    w0 = wake_cnt;
    repeat (lo) @(posedge clk);
    rd(OFS_WAKE_STATUS, "status before filter end");
    repeat (hi - lo) @(posedge clk);
    m_stat |= 1 << b;
    m_lvl = v ? (m_lvl | (1 << b)) : (m_lvl & ~(1 << b));
    rd(OFS_WAKE_STATUS, "status after filter end");
    rd(OFS_LEVEL_STATUS, "level status");
    chk(wake_cnt - w0, wk, "wake-up pulses");
  endtask

  task sleep(input logic [1:0] exp);
    @(posedge clk);
    sleep_cmd <= 1'b1;
    @(posedge clk);
    sleep_cmd <= 1'b0;
    #1 chk({go_sleep, restart}, exp, "sleep answer");
  endtask

  task end_sim;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a <= 32; a += 4) rd(a[7:0], "reset value");
    chk(sw, 1'b0, "switch after reset");
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_PULL_SELECT, i < 4 ? i * 21 : int'(seed[5:0]));
      seed = lfsr(seed);
      rd(OFS_PULL_SELECT, "pull select");
      chk_pulls();
    end
    wr(OFS_PULL_SELECT, 63);
    wr(OFS_WAKE_ENABLE, 7);
    wr(OFS_DETECT_FILTER, 0);
    for (int g = 0; g < 3; g++)
    begin
      drive[2] <= 1'b1;
      repeat (20 + seed % 250) @(posedge clk);
      seed = lfsr(seed);
      drive[2] <= 1'b0;
      repeat (400) @(posedge clk);
      rd(OFS_WAKE_STATUS, "glitch rejected");
    end
    drive[2] <= 1'b1;
    edge_chk(2, 1, 315, 325, 0);
    chk_pulls();
    wr(OFS_IRQ_MASK, 4);
    #1 chk(irq, 1'b1, "irq unmasked");
    wr(OFS_WAKE_STATUS, 4);
    #1 chk(irq, 1'b0, "irq after clear");
    // stop mode, long filter, falling edge
    mode <= 3'h2;
    wr(OFS_DETECT_FILTER, 32'h10);
    drive[2] <= 1'b0;
    edge_chk(2, 0, 1275, 1285, 0);
    wr(OFS_DETECT_FILTER, 0);
    // clear first so the early read can see a premature wake
    wr(OFS_WAKE_STATUS, 4);
    mode <= 3'h3;
    drive[2] <= 1'b1;
    edge_chk(2, 1, 315, 325, 1);
    wr(OFS_WAKE_STATUS, 4);
    mode <= 3'h5;
    drive[2] <= 1'b0;
    edge_chk(2, 0, 315, 325, 1);
    mode <= 3'h1;
    wr(OFS_WAKE_STATUS, 4);
    // cyclic sensing: the pin only moves while its timer powers the circuit
    t1 <= 1'b0;
    t2 <= 1'b0;
    wr(OFS_PULL_SELECT, 32'h10);
    wr(OFS_DETECT_FILTER, 32'h20);
    drive[2] <= 1'b1;
    repeat (400) @(posedge clk);
    t1 <= 1'b1;
    edge_chk(2, 1, 315, 325, 0);
    wr(OFS_WAKE_STATUS, 4);
    t1 <= 1'b0;
    hs_sel <= 1'b1;
    wr(OFS_DETECT_FILTER, 32'h30);
    drive[2] <= 1'b0;
    repeat (400) @(posedge clk);
    t2 <= 1'b1;
    edge_chk(2, 0, 315, 325, 0);
    wr(OFS_WAKE_STATUS, 4);
    // measurement mode
    t1 <= 1'b1;
    hs_sel <= 1'b0;
    wr(OFS_MEASURE_CTRL, 1);
    repeat (2) @(posedge clk);
    #1 chk(sw, 1'b1, "switch in normal mode");
    mode <= 3'h2;
    repeat (3) @(posedge clk);
    #1 chk(sw, 1'b0, "switch in stop mode");
    mode <= 3'h1;
    wr(OFS_PULL_SELECT, 32'h2a);
    rd(OFS_PULL_SELECT, "settings still stored");
    repeat (2) @(posedge clk);
    chk_pulls();
    wr(OFS_DETECT_FILTER, 0);
    drive[1:0] <= 2'h3;
    repeat (400) @(posedge clk);
    rd(OFS_WAKE_STATUS, "gated inputs");
    rd(OFS_LEVEL_STATUS, "gated levels");
    wr(OFS_WAKE_ENABLE, 3);
    sleep(2'b01);
    m_stat |= 8;
    rd(OFS_WAKE_STATUS, "failure flag");
    wr(OFS_WAKE_ENABLE, 7);
    sleep(2'b10);
    wr(OFS_MEASURE_CTRL, 0);
    wr(OFS_WAKE_ENABLE, 3);
    sleep(2'b10);
    // inputs one and two wake normally again once measurement is off
    repeat (400) @(posedge clk);
    m_stat |= 3;
    m_lvl |= 3;
    rd(OFS_WAKE_STATUS, "inputs one and two after measurement");
    rd(OFS_LEVEL_STATUS, "levels one and two after measurement");
    end_sim();
  end
endmodule // tb
